// ==== src/mac_table_pkg.sv ====
// Package: constants, types and register map of the address table
`default_nettype none
package mac_table_pkg;
   // ------------------------------------------------------------
   // Table geometry
   // ------------------------------------------------------------
   localparam int PORTS = 8;
   localparam int PORT_W = 3;
   localparam int TABLE_DEPTH = 8192;
   localparam logic [6:0] STATIC_MAX = 7'h40;
   typedef logic [PORTS-1:0] portset_t;
   typedef struct packed {
      logic valid;
      logic is_static;
      logic seen;
      logic [11:0] vlan;
      logic [47:0] mac;
      portset_t members;
   } entry_t;
   typedef struct packed {
      logic [PORT_W-1:0] port;
      logic [11:0] vlan;
      logic [47:0] source_station_address;
      logic [47:0] destination_station_address;
   } frame_t;
   // ------------------------------------------------------------
   // Learning modes, operations, scan states
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_OFF = 2'h1;
   localparam logic [1:0] MODE_SECURE = 2'h2;
   localparam logic [1:0] MODE_RSVD = 2'h3;
   typedef enum logic [3:0] {
      OP_FIRST = 4'h1, OP_SEEK = 4'h2, OP_NEXT = 4'h3, OP_SADD = 4'h4, OP_SDEL = 4'h5,
      OP_FRAME = 4'h8, OP_AGE = 4'h9, OP_FLUSH = 4'hA, OP_INIT = 4'hB
   } op_t;
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_SCAN = 3'h2, ST_DONE = 3'h4} state_t;
   // ------------------------------------------------------------
   // Register map (byte addresses) and fields
   // ------------------------------------------------------------
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_AGE_TIME = 12'h004;
   localparam logic [11:0] REG_LEARN_MODE = 12'h008;
   localparam logic [11:0] REG_KEY_VLAN = 12'h00C;
   localparam logic [11:0] REG_KEY_MAC_LO = 12'h010;
   localparam logic [11:0] REG_KEY_MAC_HI = 12'h014;
   localparam logic [11:0] REG_MEMBERS = 12'h018;
   localparam logic [11:0] REG_CMD = 12'h01C;
   localparam logic [11:0] REG_STATUS = 12'h020;
   localparam logic [11:0] REG_RES_VLAN = 12'h024;
   localparam logic [11:0] REG_RES_MAC_LO = 12'h028;
   localparam logic [11:0] REG_RES_MAC_HI = 12'h02C;
   localparam logic [11:0] REG_RES_MEMBERS = 12'h030;
   localparam int CTRL_AGE_OFF_BIT = 0;
   localparam int CTRL_FLUSH_BIT = 1;
   localparam int RES_TYPE_BIT = 16;
   localparam int RES_END_BIT = 17;
   localparam int STAT_CNT_POS = 8;
   // ------------------------------------------------------------
   // Aging timing
   // ------------------------------------------------------------
   localparam logic [23:0] AGE_DEFAULT_S = 24'h00012C;
   localparam logic [23:0] AGE_MIN_S = 24'h00000A;
   localparam logic [23:0] AGE_MAX_S = 24'h989680;
   localparam int CLK_PERIOD_NS = 100;
   localparam int AGE_TICK_NS = 1000000000;
   localparam int SEC_CYCLES = AGE_TICK_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ==== src/mac_table.sv ====
// Address table: learning, secure check, forwarding lookup, aging, ordered reads
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
// What this block does
// - Auto mode learns unknown source addresses
// - Disabled mode never writes the table
// - Secure mode passes only static sources
// - At most 64 static entries in free slots; making a dynamic entry static skips the cap
// - Order by VLAN, then MAC
// - Table holds up to 8192 entries
// - Entry keeps VLAN, MAC, members; editable
// - Type flag static or dynamic readable
// - Flush removes dynamic, keeps static
// - Seek returns exact or next key
// - Get-next returns successor or end
// - Get-first returns lowest VLAN/MAC
// - Locked port mode ignores writes
// - Unseen dynamic entries age out
// - Age time 10..10000000 s, default 300
// - Destination lookup selects egress ports
module mac_table #(
   parameter int DEPTH = mac_table_pkg::TABLE_DEPTH,
   parameter int SEC_CYCLES = mac_table_pkg::SEC_CYCLES
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Ingress frames
   input wire logic FRM_VALID,
   input wire mac_table_pkg::frame_t FRM,
   output logic FRM_READY,
   // Forwarding decision
   output logic FWD_VALID,
   output logic FWD_DROP,
   output mac_table_pkg::portset_t FWD_PORTS,
   // Mode lock from another control module
   input wire mac_table_pkg::portset_t MODE_LOCK
);
   localparam int IDX_W = $clog2(DEPTH);
   localparam int P = mac_table_pkg::PORTS;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   mac_table_pkg::entry_t mem [DEPTH];
   mac_table_pkg::state_t state_reg, state_next;
   mac_table_pkg::op_t op_reg, op_next;
   logic [IDX_W-1:0] idx_reg;
   mac_table_pkg::frame_t frm_reg;
   logic hit_reg, hit_static_reg, free_reg, dst_reg, best_reg;
   logic [IDX_W-1:0] hit_idx_reg, free_idx_reg;
   mac_table_pkg::portset_t dst_ports_reg;
   mac_table_pkg::entry_t best_reg_ent, res_reg;
   logic end_reg, err_reg, age_off_reg;
   logic [23:0] age_time_reg, age_sec_reg;
   logic [31:0] sec_cnt_reg;
   logic [2*P-1:0] mode_reg;
   // Nets, since each port's field is driven by its own assign
   wire [2*P-1:0] mode_next, lock_pairs;
   logic [11:0] key_vlan_reg;
   logic [47:0] key_mac_reg;
   mac_table_pkg::portset_t members_reg;
   logic [6:0] static_cnt_reg;
   logic cmd_pend_reg, age_pend_reg, flush_pend_reg;
   mac_table_pkg::op_t cmd_op_reg;
   logic [31:0] prdata_reg;
   logic pready_reg, pslverr_reg, frm_ready_reg, fwd_valid_reg, fwd_drop_reg;
   mac_table_pkg::portset_t fwd_ports_reg;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   wire setup = PSEL & ~PENABLE;
   wire apb_wr = PSEL & PENABLE & PWRITE & pready_reg;
   wire wr_ctrl = apb_wr & (PADDR == mac_table_pkg::REG_CTRL);
   wire wr_age = apb_wr & (PADDR == mac_table_pkg::REG_AGE_TIME);
   wire wr_mode = apb_wr & (PADDR == mac_table_pkg::REG_LEARN_MODE);
   wire wr_kvlan = apb_wr & (PADDR == mac_table_pkg::REG_KEY_VLAN);
   wire wr_klo = apb_wr & (PADDR == mac_table_pkg::REG_KEY_MAC_LO);
   wire wr_khi = apb_wr & (PADDR == mac_table_pkg::REG_KEY_MAC_HI);
   wire wr_memb = apb_wr & (PADDR == mac_table_pkg::REG_MEMBERS);
   wire wr_cmd = apb_wr & (PADDR == mac_table_pkg::REG_CMD);
   wire cmd_ok = (PWDATA[3:0] >= 4'h1) & (PWDATA[3:0] <= 4'h5);
   wire busy = cmd_pend_reg | flush_pend_reg | (state_reg != mac_table_pkg::ST_IDLE);
   wire mapped = (PADDR[1:0] == 2'h0) & (PADDR <= mac_table_pkg::REG_RES_MEMBERS);
   wire [23:0] age_wdata = PWDATA[23:0] < mac_table_pkg::AGE_MIN_S ? mac_table_pkg::AGE_MIN_S :
      PWDATA[23:0] > mac_table_pkg::AGE_MAX_S ? mac_table_pkg::AGE_MAX_S : PWDATA[23:0];
   logic [31:0] rd_mux;
   always_comb begin
      case (PADDR)
         mac_table_pkg::REG_CTRL: rd_mux = {31'h0, age_off_reg};
         mac_table_pkg::REG_AGE_TIME: rd_mux = {8'h00, age_time_reg};
         mac_table_pkg::REG_LEARN_MODE: rd_mux = 32'(mode_reg);
         mac_table_pkg::REG_KEY_VLAN: rd_mux = {20'h0, key_vlan_reg};
         mac_table_pkg::REG_KEY_MAC_LO: rd_mux = key_mac_reg[31:0];
         mac_table_pkg::REG_KEY_MAC_HI: rd_mux = {16'h0, key_mac_reg[47:32]};
         mac_table_pkg::REG_MEMBERS: rd_mux = 32'(members_reg);
         mac_table_pkg::REG_STATUS: rd_mux = 32'({static_cnt_reg, 5'h0, err_reg, end_reg, busy});
         mac_table_pkg::REG_RES_VLAN:
            rd_mux = {14'h0, end_reg, res_reg.is_static, 4'h0, res_reg.vlan};
         mac_table_pkg::REG_RES_MAC_LO: rd_mux = res_reg.mac[31:0];
         mac_table_pkg::REG_RES_MAC_HI: rd_mux = {16'h0, res_reg.mac[47:32]};
         mac_table_pkg::REG_RES_MEMBERS: rd_mux = 32'(res_reg.members);
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Per-port mode write, skipped while another module holds the port
   genvar gp;
   generate
      for (gp = 0; gp < P; gp++) begin : g_mode
         assign mode_next[2*gp +: 2] = (wr_mode & ~MODE_LOCK[gp] &
            (PWDATA[2*gp +: 2] != mac_table_pkg::MODE_RSVD)) ?
            PWDATA[2*gp +: 2] : mode_reg[2*gp +: 2];
         assign lock_pairs[2*gp +: 2] = {2{MODE_LOCK[gp]}};
      end
   endgenerate

   // ------------------------------------------------------------
   // Scan datapath: one entry per cycle, whole table per operation
   // ------------------------------------------------------------
   mac_table_pkg::entry_t cur, wr_ent;
   assign cur = mem[idx_reg];
   wire is_frame = (op_reg == mac_table_pkg::OP_FRAME);
   wire [11:0] q_vlan = is_frame ? frm_reg.vlan : key_vlan_reg;
   wire [47:0] q_mac = is_frame ? frm_reg.source_station_address : key_mac_reg;
   wire [59:0] q_key = {q_vlan, q_mac};
   wire [59:0] cur_key = {cur.vlan, cur.mac};
   wire hit_now = cur.valid & (cur_key == q_key);
   wire dst_now = cur.valid & (cur.vlan == frm_reg.vlan) &
      (cur.mac == frm_reg.destination_station_address);
   wire cand = cur.valid & ((op_reg == mac_table_pkg::OP_FIRST) |
      ((op_reg == mac_table_pkg::OP_SEEK) & (cur_key >= q_key)) |
      ((op_reg == mac_table_pkg::OP_NEXT) & (cur_key > q_key)));
   wire better = cand & (~best_reg | (cur_key < {best_reg_ent.vlan, best_reg_ent.mac}));
   wire last = (idx_reg == IDX_W'(DEPTH - 1));
   wire [1:0] frm_mode = mode_reg[{frm_reg.port, 1'b0} +: 2];
   wire secure_drop = (frm_mode == mac_table_pkg::MODE_SECURE) & ~(hit_reg & hit_static_reg);
   wire [P-1:0] in_port = {{(P-1){1'b0}}, 1'b1} << frm_reg.port;
   wire static_room = static_cnt_reg < mac_table_pkg::STATIC_MAX;
   wire in_scan = (state_reg == mac_table_pkg::ST_SCAN);
   wire in_done = (state_reg == mac_table_pkg::ST_DONE);

   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   always_comb begin
      wr_en = 1'b0;
      wr_idx = idx_reg;
      wr_ent = cur;
      if (in_scan) begin
         case (op_reg)
            mac_table_pkg::OP_INIT: begin
               wr_en = 1'b1;
               wr_ent = '0;
            end
            mac_table_pkg::OP_FLUSH: begin
               wr_en = cur.valid & ~cur.is_static;
               wr_ent.valid = 1'b0;
            end
            mac_table_pkg::OP_AGE: begin
               wr_en = cur.valid & ~cur.is_static;
               wr_ent.valid = cur.seen;
               wr_ent.seen = 1'b0;
            end
            mac_table_pkg::OP_SDEL: begin
               wr_en = hit_now & cur.is_static;
               wr_ent.valid = 1'b0;
            end
            default: wr_en = 1'b0;
         endcase
      end else if (in_done & is_frame & (frm_mode == mac_table_pkg::MODE_AUTO)) begin
         wr_en = hit_reg ? ~hit_static_reg : free_reg;
         wr_idx = hit_reg ? hit_idx_reg : free_idx_reg;
         wr_ent = {1'b1, 1'b0, 1'b1, frm_reg.vlan, frm_reg.source_station_address,
            in_port};
      end else if (in_done & (op_reg == mac_table_pkg::OP_SADD)) begin
         wr_en = hit_reg | (free_reg & static_room);
         wr_idx = hit_reg ? hit_idx_reg : free_idx_reg;
         wr_ent = {1'b1, 1'b1, 1'b0, key_vlan_reg, key_mac_reg, members_reg};
      end
   end

   always_ff @(posedge CLK) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_ent;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   wire frm_take = FRM_VALID & frm_ready_reg;
   wire any_pend = age_pend_reg | flush_pend_reg | cmd_pend_reg;
   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      case (state_reg)
         mac_table_pkg::ST_IDLE: begin
            if (frm_take | any_pend) begin
               state_next = mac_table_pkg::ST_SCAN;
            end
            if (frm_take) begin
               op_next = mac_table_pkg::OP_FRAME;
            end else if (age_pend_reg) begin
               op_next = mac_table_pkg::OP_AGE;
            end else if (flush_pend_reg) begin
               op_next = mac_table_pkg::OP_FLUSH;
            end else if (cmd_pend_reg) begin
               op_next = cmd_op_reg;
            end
         end
         mac_table_pkg::ST_SCAN: if (last) state_next = mac_table_pkg::ST_DONE;
         mac_table_pkg::ST_DONE: state_next = mac_table_pkg::ST_IDLE;
         default: state_next = mac_table_pkg::ST_IDLE;
      endcase
   end
   wire start = (state_reg == mac_table_pkg::ST_IDLE) & (state_next == mac_table_pkg::ST_SCAN);
   wire age_tick = (age_sec_reg >= age_time_reg) & (sec_cnt_reg == 32'(SEC_CYCLES - 1));

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= mac_table_pkg::ST_SCAN;
         op_reg <= mac_table_pkg::OP_INIT;
         idx_reg <= '0;
         frm_reg <= '0;
         {hit_reg, hit_static_reg, free_reg, dst_reg, best_reg} <= 5'h00;
         hit_idx_reg <= '0;
         free_idx_reg <= '0;
         dst_ports_reg <= '0;
         best_reg_ent <= '0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         if (start) begin
            idx_reg <= '0;
            {hit_reg, hit_static_reg, free_reg, dst_reg, best_reg} <= 5'h00;
            if (frm_take) frm_reg <= FRM;
         end else if (in_scan) begin
            idx_reg <= idx_reg + IDX_W'(1);
            if (hit_now) begin
               hit_reg <= 1'b1;
               hit_static_reg <= cur.is_static;
               hit_idx_reg <= idx_reg;
            end
            if (~cur.valid & ~free_reg) begin
               free_reg <= 1'b1;
               free_idx_reg <= idx_reg;
            end
            if (dst_now) begin
               dst_reg <= 1'b1;
               dst_ports_reg <= cur.members;
            end
            if (better) begin
               best_reg <= 1'b1;
               best_reg_ent <= cur;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Results, forwarding and bookkeeping
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         fwd_valid_reg <= 1'b0;
         fwd_drop_reg <= 1'b0;
         fwd_ports_reg <= '0;
         res_reg <= '0;
         end_reg <= 1'b0;
         err_reg <= 1'b0;
         static_cnt_reg <= 7'h00;
         frm_ready_reg <= 1'b0;
      end else begin
         fwd_valid_reg <= in_done & is_frame;
         frm_ready_reg <= (state_next == mac_table_pkg::ST_IDLE) & ~any_pend & ~start;
         if (in_done & is_frame) begin
            fwd_drop_reg <= secure_drop;
            fwd_ports_reg <= secure_drop ? '0 : (dst_reg ? dst_ports_reg : '1) & ~in_port;
         end
         if (in_done & ((op_reg == mac_table_pkg::OP_FIRST) | (op_reg == mac_table_pkg::OP_SEEK) |
               (op_reg == mac_table_pkg::OP_NEXT))) begin
            res_reg <= best_reg_ent;
            end_reg <= ~best_reg;
         end
         if (in_done & (op_reg == mac_table_pkg::OP_SADD)) begin
            err_reg <= ~wr_en;
            if (wr_en & ~(hit_reg & hit_static_reg)) static_cnt_reg <= static_cnt_reg + 7'h01;
         end else if (in_scan & (op_reg == mac_table_pkg::OP_SDEL) & wr_en) begin
            static_cnt_reg <= static_cnt_reg - 7'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Register file and pending work
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         age_off_reg <= 1'b0;
         age_time_reg <= mac_table_pkg::AGE_DEFAULT_S;
         mode_reg <= '0;
         key_vlan_reg <= 12'h000;
         key_mac_reg <= 48'h000000000000;
         members_reg <= '0;
         cmd_pend_reg <= 1'b0;
         cmd_op_reg <= mac_table_pkg::OP_FIRST;
         flush_pend_reg <= 1'b0;
         age_pend_reg <= 1'b0;
         sec_cnt_reg <= 32'h00000000;
         age_sec_reg <= 24'h000001;
      end else begin
         pready_reg <= setup;
         if (setup) begin
            prdata_reg <= rd_mux;
            pslverr_reg <= ~mapped;
         end
         mode_reg <= mode_next;
         if (wr_ctrl) age_off_reg <= PWDATA[mac_table_pkg::CTRL_AGE_OFF_BIT];
         if (wr_age) age_time_reg <= age_wdata;
         if (wr_kvlan) key_vlan_reg <= PWDATA[11:0];
         if (wr_klo) key_mac_reg[31:0] <= PWDATA;
         if (wr_khi) key_mac_reg[47:32] <= PWDATA[15:0];
         if (wr_memb) members_reg <= PWDATA[P-1:0];
         // Writes while a command is pending are dropped rather than queued
         if (wr_cmd & cmd_ok & ~cmd_pend_reg) begin
            cmd_pend_reg <= 1'b1;
            cmd_op_reg <= mac_table_pkg::op_t'(PWDATA[3:0]);
         end else if (start & ~frm_take & ~age_pend_reg & ~flush_pend_reg) begin
            cmd_pend_reg <= 1'b0;
         end
         flush_pend_reg <= (wr_ctrl & PWDATA[mac_table_pkg::CTRL_FLUSH_BIT]) |
            (flush_pend_reg & ~(start & ~frm_take & ~age_pend_reg));
         age_pend_reg <= (age_tick & ~age_off_reg) | (age_pend_reg & ~(start & ~frm_take));
         sec_cnt_reg <= (sec_cnt_reg == 32'(SEC_CYCLES - 1)) ? 32'h00000000 :
            sec_cnt_reg + 32'h00000001;
         if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
            age_sec_reg <= age_tick ? 24'h000001 : age_sec_reg + 24'h000001;
         end
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;
   assign FRM_READY = frm_ready_reg;
   assign FWD_VALID = fwd_valid_reg;
   assign FWD_DROP = fwd_drop_reg;
   assign FWD_PORTS = fwd_ports_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_auto_learn;
      @(posedge CLK) disable iff (!NRST)
      (in_done & is_frame & (frm_mode == mac_table_pkg::MODE_AUTO) & ~hit_reg & free_reg) |->
      (wr_en & wr_ent.valid & ~wr_ent.is_static & (wr_idx == free_idx_reg));
   endproperty
   a_auto_learn: assert property (p_auto_learn) else $error("unknown source not learned");
   property p_off_quiet;
      @(posedge CLK) disable iff (!NRST)
      (in_done & is_frame & (frm_mode == mac_table_pkg::MODE_OFF)) |-> !wr_en;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("disabled port wrote table");
   property p_secure_drop;
      @(posedge CLK) disable iff (!NRST)
      (in_done & is_frame & (frm_mode == mac_table_pkg::MODE_SECURE) & ~hit_reg) |=>
      (FWD_VALID & FWD_DROP & (FWD_PORTS == '0));
   endproperty
   a_secure_drop: assert property (p_secure_drop) else $error("secure frame not dropped");
   property p_static_cap;
      @(posedge CLK) disable iff (!NRST) static_cnt_reg <= mac_table_pkg::STATIC_MAX;
   endproperty
   a_static_cap: assert property (p_static_cap) else $error("static count over limit");
   property p_flush_keeps;
      @(posedge CLK) disable iff (!NRST)
      (in_scan & (op_reg == mac_table_pkg::OP_FLUSH) & wr_en) |-> (~cur.is_static & ~wr_ent.valid);
   endproperty
   a_flush_keeps: assert property (p_flush_keeps) else $error("flush touched static");
   property p_seek_order;
      @(posedge CLK) disable iff (!NRST)
      (in_done & (op_reg == mac_table_pkg::OP_SEEK) & best_reg) |=>
      ({res_reg.vlan, res_reg.mac} >= {key_vlan_reg, key_mac_reg}) & ~end_reg;
   endproperty
   a_seek_order: assert property (p_seek_order) else $error("seek result below key");
   property p_next_order;
      @(posedge CLK) disable iff (!NRST)
      (in_done & (op_reg == mac_table_pkg::OP_NEXT)) |=>
      (end_reg | ({res_reg.vlan, res_reg.mac} > {key_vlan_reg, key_mac_reg}));
   endproperty
   a_next_order: assert property (p_next_order) else $error("next result not after key");
   property p_lock_hold;
      @(posedge CLK) disable iff (!NRST)
      wr_mode |=> (((mode_reg ^ $past(mode_reg)) & $past(lock_pairs)) == '0);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked mode changed");
   property p_age_range;
      @(posedge CLK) disable iff (!NRST)
      wr_age |=> (age_time_reg >= mac_table_pkg::AGE_MIN_S) &
         (age_time_reg <= mac_table_pkg::AGE_MAX_S);
   endproperty
   a_age_range: assert property (p_age_range) else $error("age time out of range");
   property p_fwd_done;
      @(posedge CLK) disable iff (!NRST) (in_done & is_frame) |=> FWD_VALID ##1 !FWD_VALID;
   endproperty
   a_fwd_done: assert property (p_fwd_done) else $error("forward pulse wrong");
   property p_cov_fwd;
      @(posedge CLK) disable iff (!NRST) FWD_VALID & ~FWD_DROP;
   endproperty
   c_cov_fwd: cover property (p_cov_fwd);
   property p_cov_flush;
      @(posedge CLK) disable iff (!NRST) in_done & (op_reg == mac_table_pkg::OP_FLUSH);
   endproperty
   c_cov_flush: cover property (p_cov_flush);
   property p_cov_end;
      @(posedge CLK) disable iff (!NRST) in_done & (op_reg == mac_table_pkg::OP_NEXT) & ~best_reg;
   endproperty
   c_cov_end: cover property (p_cov_end);
endmodule
`default_nettype wire

// ==== tb/ingress_src.sv ====
// Ingress frame source model for the address table bench
`default_nettype none
module ingress_src (
   // Bench side
   input wire logic CLK,
   input wire logic go,
   input wire mac_table_pkg::frame_t f,
   // Frame port
   output logic FRM_VALID,
   output mac_table_pkg::frame_t FRM,
   input wire logic FRM_READY
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      FRM_VALID = 1'b0;
      FRM = '0;
   end
   // Released bus shows the inverse, so stale data never matches
   always @(posedge CLK) begin
      if (FRM_VALID && FRM_READY) begin
         FRM_VALID <= 1'b0;
         FRM <= ~FRM;
      end else if (go && !FRM_VALID) begin
         FRM_VALID <= 1'b1;
         FRM <= f;
      end
   end
endmodule
`default_nettype wire

// ==== tb/mac_table_tb_top.sv ====
// Bench for the address table: APB tasks, frame traffic, ordered reads
`default_nettype none
module mac_table_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0;
   logic [11:0] PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, rd;
   logic PREADY, PSLVERR, er, FRM_VALID, FRM_READY, FWD_VALID, FWD_DROP;
   mac_table_pkg::frame_t FRM, f = '0;
   mac_table_pkg::portset_t FWD_PORTS, lock = '0;
   int n_fail = 0, checks = 0, cyc = 0;
   mac_table #(.DEPTH(16), .SEC_CYCLES(4)) uut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .FRM_VALID(FRM_VALID), .FRM(FRM),
      .FRM_READY(FRM_READY), .FWD_VALID(FWD_VALID), .FWD_DROP(FWD_DROP),
      .FWD_PORTS(FWD_PORTS), .MODE_LOCK(lock));
   ingress_src src (.CLK(CLK), .go(go), .f(f), .FRM_VALID(FRM_VALID), .FRM(FRM),
      .FRM_READY(FRM_READY));
   initial forever #50 CLK = ~CLK;
   // Hang guard: whole run needs about a thousand cycles
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end
   task automatic test_done();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA; er = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
   endtask
   task automatic key(input logic [11:0] v, input logic [47:0] m);
      apb(1, mac_table_pkg::REG_KEY_VLAN, {20'h0, v});
      apb(1, mac_table_pkg::REG_KEY_MAC_LO, m[31:0]);
      apb(1, mac_table_pkg::REG_KEY_MAC_HI, {16'h0, m[47:32]});
   endtask
   // Issue a command, poll busy, leave the result word in rd
   task automatic cmd(input logic [3:0] op);
      apb(1, mac_table_pkg::REG_CMD, {28'h0, op});
      do apb(0, mac_table_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
      apb(0, mac_table_pkg::REG_RES_VLAN, 32'h0);
   endtask
   task automatic frame(input logic [2:0] p, input logic [11:0] v, input logic [47:0] s);
      @(posedge CLK);
      f <= {p, v, s, 48'h0000_00AA_0002};
      go <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      do @(negedge CLK); while (FWD_VALID !== 1'b1);
   endtask
   initial begin
      repeat (10) @(posedge CLK);
      NRST <= 1'b1;
      while (FRM_READY !== 1'b1) @(posedge CLK);
      apb(0, mac_table_pkg::REG_AGE_TIME, 0); chk(rd, 32'h0000012C);
      apb(1, mac_table_pkg::REG_AGE_TIME, 5);
      apb(0, mac_table_pkg::REG_AGE_TIME, 0); chk(rd, 32'h0000000A);
      apb(0, 12'h034, 0); chk({31'h0, er}, 32'h1);
      key(12'h002, 48'h0000_00AA_0002);
      apb(1, mac_table_pkg::REG_MEMBERS, 32'h0F);
      cmd(4'h4);
      frame(3'h1, 12'h001, 48'h0000_00BB_0001); chk(FWD_PORTS, 32'hFD);
      cmd(4'h1); chk(rd, 32'h00000001);
      key(12'h001, 48'h0000_00BB_0001);
      cmd(4'h3); chk(rd, 32'h00010002);
      key(12'h002, 48'h0000_00AA_0002);
      cmd(4'h3); chk({31'h0, rd[17]}, 32'h1);
      key(12'h002, 48'h0);
      cmd(4'h2); chk(rd, 32'h00010002);
      apb(1, mac_table_pkg::REG_CTRL, 32'h2);
      cmd(4'h1); chk(rd, 32'h00010002);
      apb(1, mac_table_pkg::REG_LEARN_MODE, 32'h8);
      lock <= 8'h02;
      apb(1, mac_table_pkg::REG_LEARN_MODE, 32'h10);
      apb(0, mac_table_pkg::REG_LEARN_MODE, 0); chk(rd, 32'h18);
      frame(3'h1, 12'h001, 48'h0000_00CC_0003); chk({31'h0, FWD_DROP}, 32'h1);
      frame(3'h2, 12'h001, 48'h0000_00CC_0003);
      cmd(4'h1); chk(rd, 32'h00010002);
      frame(3'h0, 12'h001, 48'h0000_00DD_0004);
      cmd(4'h1); chk(rd, 32'h00000001);
      repeat (300) @(posedge CLK);
      cmd(4'h1); chk(rd, 32'h00010002);
      frame(3'h0, 12'h002, 48'h0000_00EE_0005); chk(FWD_PORTS, 32'h0E);
      apb(0, mac_table_pkg::REG_STATUS, 0); chk({25'h0, rd[14:8]}, 32'h1);
      key(12'h002, 48'h0000_00AA_0002);
      cmd(4'h5);
      apb(0, mac_table_pkg::REG_STATUS, 0); chk({25'h0, rd[14:8]}, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
